// ==== pkg/bfie_pkg.sv ====
package bfie_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 16;
  localparam int unsigned SYNC_STAGES = 2;

  localparam logic [7:0] BOOST_EN_IDX  = 8'h0A;
  localparam logic [7:0] STRING_EN_IDX = 8'h0C;
  localparam logic [7:0] SUPPLY_IDX    = 8'h0E;

  localparam logic [15:0] BOOST_EN_RESET  = 16'hA028;
  localparam logic [15:0] STRING_EN_RESET = 16'h00AA;
  localparam logic [15:0] SUPPLY_RESET    = 16'h0000;

  localparam int unsigned BOOST_FIELDS  = 7;
  localparam int unsigned BOOST_BASE    = 2;
  localparam int unsigned STRING_FIELDS = 4;
  localparam int unsigned STRING_BASE   = 0;
  localparam int unsigned SUPPLY_FAULTS = 8;

  // Field index within the boost enable register
  localparam int unsigned OVERTEMP_F   = 6;
  localparam int unsigned CURRENT_RES_F = 5;
  localparam int unsigned BOOST_OVC_F  = 1;
  // Field index within the string enable register
  localparam int unsigned GLOBAL_F     = 3;
  // Flag index k: status bit 2k+1, cleared by writing 1 to both bits 2k+1 and 2k
  localparam int unsigned CHECKSUM_ERROR_K = 7;
  localparam int unsigned INPUT_UNDERVOLT_K = 0;

  localparam logic [1:0] EN_RD_OFF = 2'h0;
  localparam logic [1:0] EN_RD_ON  = 2'h2;
  localparam logic [1:0] EN_WR_OFF = 2'h1;
  localparam logic [1:0] EN_WR_ON  = 2'h3;

  function automatic logic [7:0] reg_addr(logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction

  function automatic logic next_enable(logic cur, logic [1:0] code);
    case (code)
      EN_WR_OFF: return 1'b0;
      EN_WR_ON:  return 1'b1;
      default:   return cur;
    endcase
  endfunction

  function automatic logic [7:0] reset_enables(logic [15:0] w, int unsigned base);
    logic [7:0] v;
    v = '0;
    for (int i = 0; i < 8; i++)
      if (base + 2 * i + 1 < REG_W) v[i] = w[base + 2 * i + 1];
    return v;
  endfunction

  function automatic logic [15:0] enable_word(logic [7:0] en, int unsigned base,
                                              int unsigned n);
    logic [15:0] w;
    w = '0;
    for (int i = 0; i < 8; i++)
      if (i < n) w[base + 2 * i +: 2] = en[i] ? EN_RD_ON : EN_RD_OFF;
    return w;
  endfunction

  function automatic logic [7:0] field_lanes(logic [3:0] strb, int unsigned base);
    logic [7:0] v;
    v = '0;
    for (int i = 0; i < 8; i++)
      v[i] = strb[((base + 2 * i) / 8) % 4];
    return v;
  endfunction
endpackage

// ==== pkg/bfie_field_if.sv ====
interface bfie_field_if #(parameter int unsigned FIELDS = 1);
  logic              wr;
  logic [2*FIELDS-1:0] codes;
  logic [FIELDS-1:0] lane_ok;
  logic [FIELDS-1:0] enabled;
  modport ctrl (output wr, output codes, output lane_ok, input enabled);
  modport bank (input wr, input codes, input lane_ok, output enabled);
endinterface

// ==== hdl/bfie_enable_bank.sv ====
module bfie_enable_bank #(
  parameter int unsigned FIELDS   = 1,
  parameter logic [7:0]  RESET_EN = 8'h00
) (
  input  wire logic  pclk,
  input  wire logic  presetn,
  bfie_field_if.bank f
);
  import bfie_pkg::*;

  if (FIELDS < 1 || FIELDS > 8) begin : g_bad
    $error("bank holds one to eight fields");
  end

  // Codes 0h and 2h leave a field alone, so read-modify-write is harmless
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f.enabled <= RESET_EN[FIELDS-1:0];
    end else if (f.wr) begin
      for (int i = 0; i < FIELDS; i++)
        if (f.lane_ok[i])
          f.enabled[i] <= next_enable(f.enabled[i], f.codes[2*i +: 2]);
    end
  end

  for (genvar g = 0; g < FIELDS; g++) begin : g_chk
    off_code_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      f.wr && f.lane_ok[g] && f.codes[2*g +: 2] == EN_WR_OFF
      |=> !f.enabled[g])
      else $error("disable code did not clear field");

    on_code_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      f.wr && f.lane_ok[g] && f.codes[2*g +: 2] == EN_WR_ON
      |=> f.enabled[g])
      else $error("enable code did not set field");

    keep_code_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !(f.wr && f.lane_ok[g] && f.codes[2*g] == 1'b1)
      |=> $stable(f.enabled[g]))
      else $error("field changed without a set or clear code");
  end
endmodule

// ==== hdl/bfie_irq_enables.sv ====
module bfie_irq_enables #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ADDR_W-1:0]       paddr,
  input  wire logic [bfie_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [bfie_pkg::DATA_W-1:0] prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [7:0]              supply_fault_raw,
  input  wire logic [7:0]              supply_irq_enable,
  input  wire logic [6:0]              boost_fault_latched,
  input  wire logic [2:0]              string_fault_latched,
  output logic      [6:0]              boost_irq_enable,
  output logic      [2:0]              string_irq_enable,
  output logic                         global_irq_enable,
  output logic      [7:0]              supply_fault_flag,
  output logic                         fault_irq
);
  import bfie_pkg::*;

  if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad
    $error("address must hold 6 to 32 bits");
  end

  if (BOOST_FIELDS != 7 || STRING_FIELDS != 4 ||
      SUPPLY_FAULTS != 8) begin : g_bad_map
    $error("port widths assume the fixed map");
  end

  // Bus phase decode

  logic sel_boost;
  logic sel_string;
  logic sel_supply;
  logic sel_any;
  logic acc_wait;
  logic acc_done;
  logic wr_done;

  assign sel_boost  = paddr == ADDR_W'(reg_addr(BOOST_EN_IDX));
  assign sel_string = paddr == ADDR_W'(reg_addr(STRING_EN_IDX));
  assign sel_supply = paddr == ADDR_W'(reg_addr(SUPPLY_IDX));
  assign sel_any    = sel_boost || sel_string || sel_supply;

  assign acc_wait = psel && penable && !pready;
  assign acc_done = psel && penable && pready;
  assign wr_done  = acc_done && pwrite;

  // One wait state: pready is a flop, so answers never race the decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= acc_wait;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= acc_wait && !sel_any;
    end
  end

  // Enable banks

  bfie_field_if #(.FIELDS(BOOST_FIELDS))  boost_if ();
  bfie_field_if #(.FIELDS(STRING_FIELDS)) string_if ();

  logic [7:0] boost_lanes;
  logic [7:0] string_lanes;

  assign boost_lanes  = field_lanes(pstrb, BOOST_BASE);
  assign string_lanes = field_lanes(pstrb, STRING_BASE);

  assign boost_if.wr      = wr_done && sel_boost;
  assign boost_if.codes   = pwdata[BOOST_BASE +: 2*BOOST_FIELDS];
  assign boost_if.lane_ok = boost_lanes[BOOST_FIELDS-1:0];

  assign string_if.wr      = wr_done && sel_string;
  assign string_if.codes   = pwdata[STRING_BASE +: 2*STRING_FIELDS];
  assign string_if.lane_ok = string_lanes[STRING_FIELDS-1:0];

  bfie_enable_bank #(
    .FIELDS   (BOOST_FIELDS),
    .RESET_EN (reset_enables(BOOST_EN_RESET, BOOST_BASE))
  ) boost_bank (
    .pclk    (pclk),
    .presetn (presetn),
    .f       (boost_if.bank)
  );

  bfie_enable_bank #(
    .FIELDS   (STRING_FIELDS),
    .RESET_EN (reset_enables(STRING_EN_RESET, STRING_BASE))
  ) string_bank (
    .pclk    (pclk),
    .presetn (presetn),
    .f       (string_if.bank)
  );

  assign boost_irq_enable  = boost_if.enabled;
  assign string_irq_enable = string_if.enabled[GLOBAL_F-1:0];
  assign global_irq_enable = string_if.enabled[GLOBAL_F];

  // Supply fault inputs come from analog comparators, so resynchronise first

  logic [SUPPLY_FAULTS-1:0] fault_meta;
  logic [SUPPLY_FAULTS-1:0] fault_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_meta <= '0;
      fault_sync <= '0;
    end else begin
      fault_meta <= supply_fault_raw;
      fault_sync <= fault_meta;
    end
  end

  // Supply flags

  logic [SUPPLY_FAULTS-1:0] supply_clear;

  always_comb begin
    for (int k = 0; k < SUPPLY_FAULTS; k++)
      supply_clear[k] = wr_done && sel_supply && pstrb[(2 * k) / 8] &&
                        pwdata[2*k+1] && pwdata[2*k];
  end

  // A fault still present keeps its flag set through a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_fault_flag <= SUPPLY_RESET[SUPPLY_FAULTS-1:0];
    end else begin
      supply_fault_flag <= fault_sync | (supply_fault_flag & ~supply_clear);
    end
  end

  // Read path

  logic [REG_W-1:0] read_word;

  always_comb begin
    read_word = '0;
    if (sel_boost) begin
      read_word = enable_word(8'(boost_if.enabled), BOOST_BASE, BOOST_FIELDS);
    end else if (sel_string) begin
      read_word = enable_word(8'(string_if.enabled), STRING_BASE, STRING_FIELDS);
    end else if (sel_supply) begin
      for (int k = 0; k < SUPPLY_FAULTS; k++)
        read_word[2*k+1] = supply_fault_flag[k];
    end
  end

  // Data is taken in the wait cycle and held while pready is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (acc_wait) begin
      prdata <= pwrite ? 32'h0000_0000 : {16'h0000, read_word};
    end
  end

  // Interrupt output

  logic irq_cause;

  assign irq_cause = |(supply_fault_flag & supply_irq_enable) ||
                     |(boost_fault_latched & boost_irq_enable) ||
                     |(string_fault_latched & string_irq_enable);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_irq <= 1'b0;
    end else begin
      fault_irq <= global_irq_enable && irq_cause;
    end
  end

  // Checks

  bus_answer_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc_wait |=> pready ##1 !pready)
    else $error("access not answered in one cycle");

  bus_error_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc_wait && !sel_any |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not flagged");

  boost_reset_a: assert property (
    @(posedge pclk)
    $rose(presetn) |-> boost_irq_enable[OVERTEMP_F] &&
    boost_irq_enable[CURRENT_RES_F] && boost_irq_enable[BOOST_OVC_F] &&
    enable_word(8'(boost_irq_enable), BOOST_BASE, BOOST_FIELDS) == BOOST_EN_RESET)
    else $error("boost enables wrong after reset");

  string_reset_a: assert property (
    @(posedge pclk)
    $rose(presetn) |-> global_irq_enable && &string_irq_enable &&
    supply_fault_flag == 8'h00)
    else $error("string enables or flags wrong after reset");

  read_codes_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc_wait && !pwrite && sel_boost
    |=> prdata[15:14] == (boost_irq_enable[OVERTEMP_F] ? EN_RD_ON : EN_RD_OFF) &&
        prdata[1:0] == 2'b00)
    else $error("boost read codes wrong");

  reserved_zero_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc_wait && !pwrite && sel_string |=> prdata[31:8] == 24'h00_0000 &&
    prdata[7:6] == (global_irq_enable ? EN_RD_ON : EN_RD_OFF))
    else $error("string read wrong");

  flag_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    supply_fault_raw[INPUT_UNDERVOLT_K] |-> ##3 supply_fault_flag[INPUT_UNDERVOLT_K])
    else $error("fault not latched in three cycles");

  flag_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_done && sel_supply && pstrb[1] && pwdata[15:14] == 2'b11 &&
    !fault_sync[CHECKSUM_ERROR_K]
    |=> !supply_fault_flag[CHECKSUM_ERROR_K])
    else $error("paired write did not clear flag");

  flag_keep_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    supply_fault_flag[CHECKSUM_ERROR_K] &&
    !(wr_done && sel_supply && pstrb[1] && pwdata[15:14] == 2'b11)
    |=> supply_fault_flag[CHECKSUM_ERROR_K])
    else $error("flag dropped without paired clear");

  irq_global_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !global_irq_enable |=> !fault_irq)
    else $error("interrupt while globally disabled");

  irq_cause_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    global_irq_enable && irq_cause |=> fault_irq ##0 $past(irq_cause))
    else $error("enabled fault raised no interrupt");

  irq_source_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    fault_irq |-> $past(irq_cause) && $past(global_irq_enable))
    else $error("interrupt without an enabled fault");
endmodule

// ==== test/bfie_apb_host.sv ====
module bfie_apb_host (
  input  wire logic                        pclk,
  input  wire logic [bfie_pkg::DATA_W-1:0] prdata,
  input  wire logic                        pready,
  input  wire logic                        pslverr,
  output logic                             psel,
  output logic                             penable,
  output logic                             pwrite,
  output logic      [7:0]                  paddr,
  output logic      [bfie_pkg::DATA_W-1:0] pwdata,
  output logic      [3:0]                  pstrb
);
  timeunit 1ns;
  timeprecision 1ns;
  import bfie_pkg::*;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'h0;
  end

  // Waits on pready without assuming a latency; the bench watchdog cuts a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released address and data lines show no stale value
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule

// ==== test/bfie_irq_enables_bench.sv ====
module bfie_irq_enables_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import bfie_pkg::*;

  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, supply_fault_raw, supply_irq_enable, supply_fault_flag;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb;
  logic [6:0]  boost_fault_latched, boost_irq_enable;
  logic [2:0]  string_fault_latched, string_irq_enable;
  logic        global_irq_enable, fault_irq, err;
  int          n_errors = 0;
  int          checks = 0;

  always #50 pclk = ~pclk;

  bfie_apb_host host_u (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb));

  bfie_irq_enables dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supply_fault_raw(supply_fault_raw),
    .supply_irq_enable(supply_irq_enable), .boost_fault_latched(boost_fault_latched),
    .string_fault_latched(string_fault_latched), .boost_irq_enable(boost_irq_enable),
    .string_irq_enable(string_irq_enable), .global_irq_enable(global_irq_enable),
    .supply_fault_flag(supply_fault_flag), .fault_irq(fault_irq));

  task automatic stop_test();
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, rdat, err);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    host_u.xfer(1'b0, a, 32'h0000_0000, rdat, err);
    chk(what, exp, rdat);
  endtask

  // Latch plus one cycle for the interrupt flop
  task automatic settle();
    repeat (6) @(posedge pclk);
  endtask

  task automatic t_reset();
    rdc("boost reg", 8'h28, 32'h0000_A028);
    rdc("string reg", 8'h30, 32'h0000_00AA);
    rdc("supply reg", 8'h38, 32'h0000_0000);
    chk("mapped err", 32'h0000_0000, {31'h0, err});
    chk("boost ports", 32'h0000_0063, {25'h0, boost_irq_enable});
    chk("string ports", 32'h0000_0007, {29'h0, string_irq_enable});
    chk("global port", 32'h0000_0001, {31'h0, global_irq_enable});
  endtask

  task automatic t_codes();
    wr(8'h28, 32'h0000_5557);
    rdc("boost all off", 8'h28, 32'h0000_0000);
    wr(8'h28, 32'hFFFF_FFFF);
    rdc("boost all on", 8'h28, 32'h0000_AAA8);
    wr(8'h28, 32'h0000_0000);
    rdc("code 0 ignored", 8'h28, 32'h0000_AAA8);
    wr(8'h28, 32'h0000_1C00);
    rdc("mixed codes", 8'h28, 32'h0000_8AA8);
    wr(8'h28, 32'h0000_5554);
    wr(8'h28, 32'h0000_AAA8);
    rdc("code 2 ignored", 8'h28, 32'h0000_0000);
    chk("boost ports off", 32'h0000_0000, {25'h0, boost_irq_enable});
    wr(8'h30, 32'h0000_FF55);
    rdc("string all off", 8'h30, 32'h0000_0000);
    chk("global off", 32'h0000_0000, {31'h0, global_irq_enable});
    wr(8'h30, 32'h0000_FFFF);
    rdc("string all on", 8'h30, 32'h0000_00AA);
    wr(8'h28, 32'h0000_FFFC);
  endtask

  task automatic t_unmapped();
    host_u.xfer(1'b0, 8'h2C, 32'h0000_0000, rdat, err);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
    chk("unmapped data", 32'h0000_0000, rdat);
  endtask

  task automatic t_supply();
    for (int k = 0; k < 8; k++) begin
      @(posedge pclk);
      supply_irq_enable <= 8'h01 << k;
      supply_fault_raw  <= 8'h01 << k;
      settle();
      supply_fault_raw  <= 8'h00;
      rdc("flag set", 8'h38, 32'h0000_0002 << (2 * k));
      chk("irq on flag", 32'h0000_0001, {31'h0, fault_irq});
      wr(8'h38, 32'h0000_0001 << (2 * k));
      rdc("clear alone", 8'h38, 32'h0000_0002 << (2 * k));
      wr(8'h38, 32'h0000_0003 << (2 * k));
      settle();
      rdc("flag cleared", 8'h38, 32'h0000_0000);
      chk("irq cleared", 32'h0000_0000, {31'h0, fault_irq});
    end
  endtask

  task automatic t_irq();
    @(posedge pclk);
    boost_fault_latched <= 7'h01 << OVERTEMP_F;
    settle();
    chk("irq boost", 32'h0000_0001, {31'h0, fault_irq});
    wr(8'h30, 32'h0000_0040);
    settle();
    chk("irq global off", 32'h0000_0000, {31'h0, fault_irq});
    wr(8'h30, 32'h0000_00C0);
    wr(8'h28, 32'h0000_4000);
    settle();
    chk("irq source off", 32'h0000_0000, {31'h0, fault_irq});
    string_fault_latched <= 3'b001;
    settle();
    chk("irq string", 32'h0000_0001, {31'h0, fault_irq});
  endtask

  initial begin
    presetn = 1'b0;
    supply_fault_raw = 8'h00;
    supply_irq_enable = 8'h00;
    boost_fault_latched = 7'h00;
    string_fault_latched = 3'b000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_codes();
    t_unmapped();
    t_supply();
    t_irq();
    stop_test();
  end

  initial begin
    #1000000;
    n_errors++;
    stop_test();
  end
endmodule
